//--- dv/gpp_pins_model.sv
// ----------------------------------------
// Pins and peripherals around the port
// ----------------------------------------
module gpp_pins_model
  import gpp_pkg::*;
(
  input  wire logic         ref_clk_i,
  input  wire logic [W-1:0] pad_out_i,
  input  wire logic [W-1:0] pad_oe_i,
  input  wire logic [W-1:0] pad_pu_i,
  input  wire logic [W-1:0] pad_pd_i,
  input  wire logic [W-1:0] ext_en_i,
  input  wire logic [W-1:0] ext_val_i,
  output logic      [W-1:0] pad_in_o,
  output logic      [W-1:0] alt_out_o,
  output logic      [W-1:0] alt_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [W-1:0] flt_q = 8'h55;  // Released lane pattern
  logic [W-1:0] alt_q = 8'h3c;  // Peripheral data
  // Floating lanes and peripheral data change every cycle
  always_ff @(posedge ref_clk_i) begin
    flt_q <= ~flt_q;
    alt_q <= ~alt_q;
  end
  assign alt_out_o = alt_q;
  assign alt_oe_o  = 8'h90;  // Peripherals drive debug lane and lane four
  // Wire level: port, then external driver, then pulls
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pad_in_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                    pad_pu_i[i] ? 1'b1 : pad_pd_i[i] ? 1'b0 : flt_q[i];
    end
  end
endmodule // gpp_pins_model

//--- dv/gpp_port_chk.sv
// ----------------------------------------
// Port level checks
// ----------------------------------------
module gpp_port_chk
  import gpp_pkg::*;
#(
  parameter int           PORT_ID  = 0,
  parameter logic [W-1:0] PIN_MASK = 8'hff
) (
  input wire logic          ref_clk_i,
  input wire logic          rst_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic          irq_o,
  input wire logic [W-1:0]  pad_oe_o,
  input wire logic [W-1:0]  pad_pu_o,
  input wire logic [W-1:0]  pad_pd_o,
  input wire logic [W-1:0]  pad_ana_o,
  input wire logic [W-1:0]  alt_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [AW-1:0] BASE = port_base(PORT_ID); // Own window
  localparam logic [W-1:0]  DBG  = dbg_pins(PORT_ID);  // Debug lanes
  logic [W-1:0] drv;                                   // Any drive or pull
  assign drv = pad_oe_o | pad_pu_o | pad_pd_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_rst_quiet; $past(rst_i, 2) |-> (drv & ~DBG) == 8'h00; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("lane driven after reset");
  property p_dbg_rst;
    ($past(rst_i, 2) && !$past(rst_i)) |->
      ((pad_oe_o & DBG) == ($past(alt_oe_i) & DBG)) && ((pad_pu_o & DBG) == DBG);
  endproperty
  a_dbg_rst: assert property (p_dbg_rst) else $error("debug lane not alternate");
  property p_foreign; rd_i && (addr_i[31:12] != BASE[31:12]) |=> rdata_o == '0; endproperty
  a_foreign: assert property (p_foreign) else $error("foreign read answered");
  property p_stand; !rd_i |=> rdata_o == '0; endproperty
  a_stand: assert property (p_stand) else $error("read data outside slot");
  property p_commit_ro;
    rd_i && (addr_i == BASE + AW'(OFS_COMMIT)) |=>
      (rdata_o[7:0] & ~DBG & PIN_MASK) == (~DBG & PIN_MASK);
  endproperty
  a_commit_ro: assert property (p_commit_ro) else $error("commit bit not fixed");
  property p_mask_off;
    wr_i && (addr_i == BASE + AW'(OFS_MASK)) && (wdata_i[7:0] == 8'h00) |-> ##2 !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked port interrupt");
  property p_unconn; (drv & ~PIN_MASK) == 8'h00; endproperty
  a_unconn: assert property (p_unconn) else $error("unconnected lane active");
  property p_analog; (pad_ana_o & drv) == 8'h00; endproperty
  a_analog: assert property (p_analog) else $error("analog lane driven");
  c_irq: cover property ($rose(irq_o));
  c_commit: cover property (rd_i && (addr_i == BASE + AW'(OFS_COMMIT)));
  c_release: cover property ($past(rst_i, 2) && !$past(rst_i));
endmodule // gpp_port_chk
bind gpp_port gpp_port_chk #(.PORT_ID(PORT_ID), .PIN_MASK(PIN_MASK)) i_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pad_oe_o(pad_oe_o),
  .pad_pu_o(pad_pu_o), .pad_pd_o(pad_pd_o), .pad_ana_o(pad_ana_o), .alt_oe_i(alt_oe_i));

//--- dv/tb_gpp_port.sv
// ----------------------------------------
// Self-checking bench for the port
// ----------------------------------------
module tb_gpp_port
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [W-1:0]  PMASK   = 8'hbf;          // Lane six unconnected
  localparam logic [DW-1:0] KEY     = 32'h0000_5a5a;  // Arbitrary unlock value
  localparam logic [AW-1:0] BASE    = 32'h4000_5000;  // Second port window
  localparam logic [AW-1:0] FOREIGN = 32'h4000_6000;  // Neighbour window
  typedef struct packed {logic [DW-1:0] v; logic [DW-1:0] m;} gpp_exp_s;
  logic          ref_clk_i = 1'b0;
  logic          rst_i     = 1'b1;
  logic          wr_i      = 1'b0;
  logic          rd_i      = 1'b0;
  logic          rd_d      = 1'b0;
  logic [AW-1:0] addr_i    = '0;
  logic [AW-1:0] win       = BASE;
  logic [DW-1:0] wdata_i   = '0;
  logic [DW-1:0] rdata_o;
  logic [31:0]   seed      = 32'hd943433f;
  logic [31:0]   r;
  logic          irq_o;
  logic [W-1:0]  pad_in_i, pad_out_o, pad_oe_o, pad_pu_o, pad_pd_o, pad_ana_o;
  logic [W-1:0]  pad_dr4_o, pad_dr8_o, pad_slew_o, alt_in_o;  // Drive, slew, peripheral input
  logic [W-1:0]  alt_out_i, alt_oe_i;
  logic [W-1:0]  ext_en    = 8'h00;
  logic [W-1:0]  ext_val   = 8'h08;
  int            fail_count = 0;
  int            tests_run  = 0;
  gpp_exp_s      exp_q[$];
  gpp_port #(.PORT_ID(PORT_B), .PIN_MASK(PMASK), .LOCK_KEY(KEY)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o), .pad_pd_o(pad_pd_o),
    .pad_dr4_o(pad_dr4_o), .pad_dr8_o(pad_dr8_o), .pad_slew_o(pad_slew_o), .pad_ana_o(pad_ana_o),
    .alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i), .alt_in_o(alt_in_o));
  gpp_pins_model i_pins (
    .ref_clk_i(ref_clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pad_pu_i(pad_pu_o),
    .pad_pd_i(pad_pd_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_in_o(pad_in_i),
    .alt_out_o(alt_out_i), .alt_oe_o(alt_oe_i));
  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // One cycle write in the current window
  task automatic wr(input logic [OFS_W-1:0] o, input logic [DW-1:0] d);
    @(posedge ref_clk_i);
    addr_i  <= win | AW'(o);
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask
  // One cycle read, expectation noted for the monitor
  task automatic rd(input logic [OFS_W-1:0] o, input logic [W-1:0] v, input logic [W-1:0] m);
    @(posedge ref_clk_i);
    addr_i <= win | AW'(o);
    rd_i   <= 1'b1;
    exp_q.push_back({DW'(v), DW'(m)});
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Read data stand in the cycle after the strobe
  always @(posedge ref_clk_i) begin
    rd_d <= rd_i;
    if (rd_d && exp_q.size() > 0) begin
      check(rdata_o & exp_q[0].m, exp_q[0].v & exp_q[0].m);
      void'(exp_q.pop_front());
    end
  end
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100us;
    fail_count++;
    final_report();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wt(4);  // Reset released; settle before first access
    rd(OFS_AFSEL, 8'h80, PMASK);
    rd(OFS_PUR, 8'h80, PMASK);
    rd(OFS_DEN, 8'h80, PMASK);
    rd(OFS_PDR, 8'h00, PMASK);
    rd(OFS_COMMIT, 8'h7f, PMASK);
    wt(1);
    check(DW'(pad_oe_o & 8'h7f), 32'h0);
    check(DW'(pad_pu_o), 32'h80);
    // Commit and lock protection
    wr(OFS_COMMIT, 32'hff);
    rd(OFS_COMMIT, 8'h7f, PMASK);
    wr(OFS_AFSEL, 32'h0);
    rd(OFS_AFSEL, 8'h80, PMASK);
    wr(OFS_LOCK, KEY);
    wr(OFS_COMMIT, 32'hff);
    rd(OFS_COMMIT, 8'hff, PMASK);
    wr(OFS_AFSEL, 32'h10);
    rd(OFS_AFSEL, 8'h10, PMASK);
    wr(OFS_LOCK, 32'h0);
    // Random lanes, unconnected lane ignored
    for (int i = 0; i < 4; i++) begin
      r = xs();
      wr(OFS_DIR, r);
      rd(OFS_DIR, r[7:0], PMASK);
    end
    wr(OFS_DIR, 32'hff);
    win = FOREIGN;
    wr(OFS_DIR, 32'h0);
    rd(OFS_DIR, 8'h00, 8'hff);
    win = BASE;
    rd(OFS_DIR, 8'hff, PMASK);
    // Outputs, open drain, peripheral lane
    wr(OFS_DEN, 32'hff);
    wr(OFS_DIR, 32'h0f);
    wr(OFS_ODR, 32'h03);
    wr(OFS_PUR, 32'h03);
    wr(12'h3fc, 32'h05);
    wr(OFS_DR8, 32'h30);
    wr(OFS_DR4, 32'h10);
    wr(OFS_SLR, 32'h30);
    wt(2);
    check(DW'(pad_oe_o & 8'h0f), 32'h0e);
    check(DW'(pad_out_o & 8'h0f), 32'h04);
    check(DW'(pad_pu_o & 8'h03), 32'h0);
    check(DW'(pad_oe_o & 8'h10), 32'h10);
    check(DW'(alt_in_o & 8'h10), DW'(alt_out_i & 8'h10));
    check(DW'(pad_dr4_o & 8'h30), 32'h10);
    check(DW'(pad_dr8_o & 8'h30), 32'h0);
    check(DW'(pad_slew_o & 8'h30), 32'h10);
    wr(OFS_DEN, 32'hdf);
    wt(2);
    check(DW'(pad_ana_o & 8'h24), 32'h20);
    // Interrupts: lane three falling masked, lane two rising passed
    ext_en <= 8'h0c;
    wr(OFS_DIR, 32'h0);
    wr(OFS_EVENT, 32'h04);
    wr(OFS_MASK, 32'h04);
    wt(8);
    wr(OFS_CLEAR, 32'hff);
    rd(OFS_RAW, 8'h00, 8'h0c);
    ext_val <= 8'h00;
    wt(8);
    check(DW'(irq_o), 32'h0);
    rd(OFS_RAW, 8'h08, 8'h0c);
    ext_val <= 8'h04;
    wt(8);
    check(DW'(irq_o), 32'h1);
    wr(OFS_CLEAR, 32'h0);
    wt(2);
    check(DW'(irq_o), 32'h1);
    wr(OFS_CLEAR, 32'h04);
    wt(2);
    check(DW'(irq_o), 32'h0);
    ext_val <= 8'h00;
    wt(8);
    rd(OFS_RAW, 8'h00, 8'h04);
    wr(OFS_BOTH, 32'h04);
    ext_val <= 8'h04;
    wt(8);
    rd(OFS_RAW, 8'h04, 8'h04);
    ext_val <= 8'h00;
    wt(8);
    rd(OFS_RAW, 8'h04, 8'h04);
    wr(OFS_BOTH, 32'h0);
    wr(OFS_SENSE, 32'h04);
    wt(8);
    rd(OFS_RAW, 8'h00, 8'h04);
    ext_val <= 8'h04;
    wt(8);
    wr(OFS_CLEAR, 32'h04);
    rd(OFS_RAW, 8'h04, 8'h04);
    wr(OFS_MASK, 32'h0);
    wt(3);
    check(DW'(irq_o), 32'h0);
    // Reset again in mid-run
    rst_i <= 1'b1;
    wt(3);
    rst_i <= 1'b0;
    wt(4);
    rd(OFS_AFSEL, 8'h80, PMASK);
    rd(OFS_COMMIT, 8'h7f, PMASK);
    wt(3);
    final_report();
  end
endmodule // tb_gpp_port

//--- include/gpp_pad_if.sv
// ----------------------------------------
// Pad configuration bundle
// ----------------------------------------
interface gpp_pad_if #(parameter int W = 8);
  logic [W-1:0] afsel;    // Alternate function select
  logic [W-1:0] dir;      // Direction, 1 output
  logic [W-1:0] open_drain_select;      // Open drain select
  logic [W-1:0] den;      // Digital pad enable
  logic [W-1:0] pur;      // Pull up enable
  logic [W-1:0] pdr;      // Pull down enable
  logic [W-1:0] dr4;      // Drive 4 ma select
  logic [W-1:0] dr8;      // Drive 8 ma select
  logic [W-1:0] slew_rate_control;      // Slew rate control
  logic [W-1:0] dout;     // Software output data
  logic [W-1:0] alt_out;  // Peripheral output data
  logic [W-1:0] alt_oe;   // Peripheral output enable
  modport ctrl (output afsel, dir, open_drain_select, den, pur, pdr, dr4, dr8, slew_rate_control,
                output dout, alt_out, alt_oe);
  modport pad  (input afsel, dir, open_drain_select, den, pur, pdr, dr4, dr8, slew_rate_control,
                input dout, alt_out, alt_oe);
endinterface

//--- include/gpp_pkg.sv
// ----------------------------------------
// Shared constants for the GPIO port
// ----------------------------------------
package gpp_pkg;
  localparam int W     = 8;              // Pads per port
  localparam int AW    = 32;             // Bus address width
  localparam int DW    = 32;             // Bus data width
  localparam int OFS_W = 12;             // Offset field width
  localparam int MSK_L = 2;              // Data mask lsb in offset
  localparam int NPORT = 8;              // Ports in the device
  localparam int LO_N  = 4;              // Ports in the low group

  // Port bases and spacing
  localparam logic [AW-1:0] BASE_LO = 32'h4000_4000;
  localparam logic [AW-1:0] BASE_HI = 32'h4002_4000;
  localparam logic [AW-1:0] STEP    = 32'h0000_1000;

  // Register offsets
  localparam logic [OFS_W-1:0] OFS_DATA_END = 12'h400;
  localparam logic [OFS_W-1:0] OFS_DIR      = 12'h400;
  localparam logic [OFS_W-1:0] OFS_SENSE    = 12'h404;
  localparam logic [OFS_W-1:0] OFS_BOTH     = 12'h408;
  localparam logic [OFS_W-1:0] OFS_EVENT    = 12'h40c;
  localparam logic [OFS_W-1:0] OFS_MASK     = 12'h410;
  localparam logic [OFS_W-1:0] OFS_RAW      = 12'h414;
  localparam logic [OFS_W-1:0] OFS_MSKD     = 12'h418;
  localparam logic [OFS_W-1:0] OFS_CLEAR    = 12'h41c;
  localparam logic [OFS_W-1:0] OFS_AFSEL    = 12'h420;
  localparam logic [OFS_W-1:0] OFS_DR2      = 12'h500;
  localparam logic [OFS_W-1:0] OFS_DR4      = 12'h504;
  localparam logic [OFS_W-1:0] OFS_DR8      = 12'h508;
  localparam logic [OFS_W-1:0] OFS_ODR      = 12'h50c;
  localparam logic [OFS_W-1:0] OFS_PUR      = 12'h510;
  localparam logic [OFS_W-1:0] OFS_PDR      = 12'h514;
  localparam logic [OFS_W-1:0] OFS_SLR      = 12'h518;
  localparam logic [OFS_W-1:0] OFS_DEN      = 12'h51c;
  localparam logic [OFS_W-1:0] OFS_LOCK     = 12'h520;
  localparam logic [OFS_W-1:0] OFS_COMMIT   = 12'h524;

  // Debug pins and reset values
  localparam int          PORT_B  = 1;
  localparam int          PORT_C  = 2;
  localparam logic [W-1:0] DBG_B  = 8'h80;  // Port b bit seven
  localparam logic [W-1:0] DBG_C  = 8'h0f;  // Port c low nibble
  localparam logic [W-1:0] ZERO   = 8'h00;
  localparam logic [W-1:0] ONES   = 8'hff;

  // Debug pins of a port
  function automatic logic [W-1:0] dbg_pins(input int p);
    return (p == PORT_B) ? DBG_B : (p == PORT_C) ? DBG_C : ZERO;
  endfunction

  // Base address of a port
  function automatic logic [AW-1:0] port_base(input int p);
    if (p < LO_N) begin
      return BASE_LO + STEP * AW'(p);
    end
    return BASE_HI + STEP * AW'(p - LO_N);
  endfunction

  // Merge new bits under a write mask
  function automatic logic [W-1:0] merge(input logic [W-1:0] o,
                                         input logic [W-1:0] n,
                                         input logic [W-1:0] m);
    return (o & ~m) | (n & m);
  endfunction
endpackage

//--- logic/gpp_pad.sv
// ----------------------------------------
// Pad steering, registered pin controls
// ----------------------------------------
module gpp_pad #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  gpp_pad_if.pad            cfg,
  output logic      [W-1:0] out_o,
  output logic      [W-1:0] oe_o,
  output logic      [W-1:0] pu_o,
  output logic      [W-1:0] pd_o,
  output logic      [W-1:0] dr4_o,
  output logic      [W-1:0] dr8_o,
  output logic      [W-1:0] slew_o,
  output logic      [W-1:0] ana_o
);
  typedef struct packed {
    logic [W-1:0] out, oe, pu, pd, dr4, dr8, slew, ana;
  } gpp_pad_s;

  gpp_pad_s     r, next_r;
  logic [W-1:0] gpio;  // Software owned pads
  logic [W-1:0] alt;   // Peripheral owned pads
  logic [W-1:0] drv;   // Pads that may drive
  logic [W-1:0] val;   // Level to present

  // Mode decode per pad
  always_comb begin
    gpio   = ~cfg.afsel & cfg.den;
    alt    = cfg.afsel & cfg.den;
    drv    = (gpio & cfg.dir) | (alt & cfg.alt_oe);
    val    = (gpio & cfg.dout) | (alt & cfg.alt_out);
    next_r = r;
    // Open drain only ever pulls low
    next_r.oe   = drv & ~(cfg.open_drain_select & val);
    next_r.out  = val & ~cfg.open_drain_select;
    // Pulls ignored in open drain
    next_r.pu   = cfg.pur & ~cfg.open_drain_select;
    next_r.pd   = cfg.pdr & ~cfg.open_drain_select;
    // Drive and slew meaningless on inputs
    next_r.dr4  = cfg.dr4 & drv;
    next_r.dr8  = cfg.dr8 & drv;
    next_r.slew = cfg.slew_rate_control & drv;
    // Analog path needs select, direction, open drain, enable and pulls clear
    next_r.ana  = ~(cfg.afsel | cfg.dir | cfg.open_drain_select | cfg.den |
                    cfg.pur | cfg.pdr);
  end

  // State register; reset leaves pads undriven
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign out_o  = r.out;
  assign oe_o   = r.oe;
  assign pu_o   = r.pu;
  assign pd_o   = r.pd;
  assign dr4_o  = r.dr4;
  assign dr8_o  = r.dr8;
  assign slew_o = r.slew;
  assign ana_o  = r.ana;
endmodule // gpp_pad

//--- logic/gpp_port.sv
// Operation
// - Non-debug pads reset undriven, controls zero except 2 ma drive
// - Unconnected bit writes change nothing
// - Unconnected bit reads are undefined
// - Debug pins reset to debug function
// - Other ports reset select, pull, enable zero
// - Port b resets 0x80, port c 0x0f
// - Commit bits writable only on debug pins
// - Commit resets ff, 7f, f0 by port
// - Decode offsets from own port base
// - Gpio mode direction and open drain
// - Alternate mode peripheral drives pad
// - Drive ignored on inputs; analog needs select, dir, drain, enable, pulls clear
// - Sense, both edges, event, mask encodings
// - Only unmasked pins raise port interrupt
// - Protected select writes need unlock, commit
// - Clear writes of one clear latched edge
module gpp_port
  import gpp_pkg::*;
#(
  parameter int                  PORT_ID  = 0,
  parameter logic [W-1:0]        PIN_MASK = 8'hff,
  parameter logic [gpp_pkg::DW-1:0] LOCK_KEY = 32'h0000_5a5a  // Arbitrary
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  input  wire logic [gpp_pkg::AW-1:0]  addr_i,
  input  wire logic [gpp_pkg::DW-1:0]  wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [gpp_pkg::DW-1:0]  rdata_o,
  output logic                         irq_o,
  input  wire logic [gpp_pkg::W-1:0]   pad_in_i,
  output logic      [gpp_pkg::W-1:0]   pad_out_o,
  output logic      [gpp_pkg::W-1:0]   pad_oe_o,
  output logic      [gpp_pkg::W-1:0]   pad_pu_o,
  output logic      [gpp_pkg::W-1:0]   pad_pd_o,
  output logic      [gpp_pkg::W-1:0]   pad_dr4_o,
  output logic      [gpp_pkg::W-1:0]   pad_dr8_o,
  output logic      [gpp_pkg::W-1:0]   pad_slew_o,
  output logic      [gpp_pkg::W-1:0]   pad_ana_o,
  input  wire logic [gpp_pkg::W-1:0]   alt_out_i,
  input  wire logic [gpp_pkg::W-1:0]   alt_oe_i,
  output logic      [gpp_pkg::W-1:0]   alt_in_o
);
  import gpp_pkg::*;

  // ----------------------------------------
  // Port constants
  // ----------------------------------------
  localparam logic [AW-1:0] BASE = port_base(PORT_ID);
  localparam logic [W-1:0]  DBG  = dbg_pins(PORT_ID);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [W-1:0]  data;    // Output data
    logic [W-1:0]  dir;     // Direction
    logic [W-1:0]  sense;   // Interrupt sense select
    logic [W-1:0]  both;    // Interrupt both edges
    logic [W-1:0]  event_p; // Interrupt event polarity
    logic [W-1:0]  mask;    // Interrupt mask
    logic [W-1:0]  raw;     // Sticky interrupt status
    logic [W-1:0]  afsel;   // Alternate function select
    logic [W-1:0]  dr2;     // Drive 2 ma select
    logic [W-1:0]  dr4;     // Drive 4 ma select
    logic [W-1:0]  dr8;     // Drive 8 ma select
    logic [W-1:0]  open_drain_select;     // Open drain select
    logic [W-1:0]  pur;     // Pull up enable
    logic [W-1:0]  pdr;     // Pull down enable
    logic [W-1:0]  slew_rate_control;     // Slew rate control
    logic [W-1:0]  den;     // Digital pad enable
    logic [W-1:0]  commit;  // Commit enable
    logic [W-1:0]  prev;    // Last input sample
    logic [W-1:0]  alt_in;  // Input to peripherals
    logic          locked;  // Commit lock state
    logic          irq;     // Interrupt line
    logic [DW-1:0] rdata;   // Read answer
  } gpp_port_s;

  // Reset image, debug pins owned by debug logic
  localparam gpp_port_s RST = '{
    data: ZERO, dir: ZERO, sense: ZERO, both: ZERO, event_p: ZERO,
    mask: ZERO, raw: ZERO,
    afsel: DBG, pur: DBG, den: DBG,
    dr2: ONES, dr4: ZERO, dr8: ZERO, open_drain_select: ZERO, pdr: ZERO, slew_rate_control: ZERO,
    commit: ~DBG,
    prev: ZERO, alt_in: ZERO, locked: 1'b1, irq: 1'b0, rdata: '0};

  gpp_port_s        r, next_r;
  logic             sel;       // Access hits this port
  logic [OFS_W-1:0] off;       // Offset inside port
  logic [W-1:0]     wd;        // Write data, pad lanes
  logic [W-1:0]     wm;        // Writable pad lanes
  logic [W-1:0]     dmask;     // Data address mask
  logic [W-1:0]     in_s;      // Synchronised pads
  logic [W-1:0]     din;       // Digital input value
  logic [W-1:0]     edge_hit;  // Edge events
  logic [W-1:0]     lvl_hit;   // Level events
  logic [W-1:0]     hit;       // Selected events
  logic [W-1:0]     clr;       // Status clear request
  logic [W-1:0]     rd;        // Read value

  // ----------------------------------------
  // Pad input synchroniser
  // ----------------------------------------
  gpp_sync #(.W(W)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (pad_in_i),
    .q_o       (in_s)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r       = r;
    next_r.rdata = '0;
    sel   = (addr_i[AW-1:OFS_W] == BASE[AW-1:OFS_W]);
    off   = addr_i[OFS_W-1:0];
    wd    = wdata_i[W-1:0];
    wm    = PIN_MASK;
    dmask = off[MSK_L +: W];
    clr   = ZERO;
    rd    = ZERO;
    // Digital disable reads low
    din         = in_s & r.den;
    next_r.prev = din;
    // Event detection
    edge_hit = (r.both & (din ^ r.prev)) |
               (~r.both & r.event_p & din & ~r.prev) |
               (~r.both & ~r.event_p & ~din & r.prev);
    lvl_hit  = ~(din ^ r.event_p);
    hit      = (r.sense & lvl_hit) | (~r.sense & edge_hit);

    // Register writes
    if (wr_i && sel) begin
      if (off < OFS_DATA_END) begin
        // Address bits pick which data bits change
        next_r.data = merge(r.data, wd, wm & dmask);
      end else begin
        case (off)
          OFS_DIR:   next_r.dir     = merge(r.dir, wd, wm);
          OFS_SENSE: next_r.sense   = merge(r.sense, wd, wm);
          OFS_BOTH:  next_r.both    = merge(r.both, wd, wm);
          OFS_EVENT: next_r.event_p = merge(r.event_p, wd, wm);
          OFS_MASK:  next_r.mask    = merge(r.mask, wd, wm);
          OFS_CLEAR: clr            = wd & wm;
          OFS_AFSEL: begin
            // Protected lanes need unlock and commit
            next_r.afsel = merge(r.afsel, wd,
              wm & (~DBG | (r.commit & {W{~r.locked}})));
          end
          OFS_DR2: begin
            // Drive selects are mutually exclusive
            next_r.dr2 = merge(r.dr2, wd, wm);
            next_r.dr4 = r.dr4 & ~(wd & wm);
            next_r.dr8 = r.dr8 & ~(wd & wm);
          end
          OFS_DR4: begin
            next_r.dr4 = merge(r.dr4, wd, wm);
            next_r.dr2 = r.dr2 & ~(wd & wm);
            next_r.dr8 = r.dr8 & ~(wd & wm);
          end
          OFS_DR8: begin
            next_r.dr8 = merge(r.dr8, wd, wm);
            next_r.dr2 = r.dr2 & ~(wd & wm);
            next_r.dr4 = r.dr4 & ~(wd & wm);
          end
          OFS_ODR:   next_r.open_drain_select = merge(r.open_drain_select, wd, wm);
          OFS_PUR:   next_r.pur = merge(r.pur, wd, wm);
          OFS_PDR:   next_r.pdr = merge(r.pdr, wd, wm);
          OFS_SLR:   next_r.slew_rate_control = merge(r.slew_rate_control, wd, wm);
          OFS_DEN:   next_r.den = merge(r.den, wd, wm);
          // Key unlocks, anything else locks
          OFS_LOCK:  next_r.locked = (wdata_i != LOCK_KEY);
          OFS_COMMIT: begin
            if (!r.locked) begin
              next_r.commit = merge(r.commit, wd, wm & DBG);
            end
          end
          default: ;  // Unmapped, ignored
        endcase
      end
    end

    // Register reads; unconnected lanes not defined
    if (rd_i && sel) begin
      if (off < OFS_DATA_END) begin
        rd = ((r.dir & r.data) | (~r.dir & din)) & dmask;
      end else begin
        case (off)
          OFS_DIR:    rd = r.dir;
          OFS_SENSE:  rd = r.sense;
          OFS_BOTH:   rd = r.both;
          OFS_EVENT:  rd = r.event_p;
          OFS_MASK:   rd = r.mask;
          OFS_RAW: begin
            // Reading status clears it
            rd  = r.raw;
            clr = clr | r.raw;
          end
          OFS_MSKD: begin
            rd  = r.raw & r.mask;
            clr = clr | (r.raw & r.mask);
          end
          OFS_AFSEL:  rd = r.afsel;
          OFS_DR2:    rd = r.dr2;
          OFS_DR4:    rd = r.dr4;
          OFS_DR8:    rd = r.dr8;
          OFS_ODR:    rd = r.open_drain_select;
          OFS_PUR:    rd = r.pur;
          OFS_PDR:    rd = r.pdr;
          OFS_SLR:    rd = r.slew_rate_control;
          OFS_DEN:    rd = r.den;
          OFS_LOCK:   rd = W'(r.locked);
          OFS_COMMIT: rd = r.commit;
          default:    rd = ZERO;  // Unmapped reads zero
        endcase
      end
      next_r.rdata = DW'(rd);
    end

    // New events win over a clear
    next_r.raw    = (r.raw & ~clr) | hit;
    // Only unmasked lanes reach the line
    next_r.irq    = |(next_r.raw & next_r.mask);
    next_r.alt_in = din & r.afsel;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= RST;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Pad steering
  // ----------------------------------------
  gpp_pad_if #(.W(W)) pif ();

  assign pif.afsel   = r.afsel;
  assign pif.dir     = r.dir;
  assign pif.open_drain_select     = r.open_drain_select;
  assign pif.den     = r.den;
  assign pif.pur     = r.pur;
  assign pif.pdr     = r.pdr;
  assign pif.dr4     = r.dr4;
  assign pif.dr8     = r.dr8;
  assign pif.slew_rate_control     = r.slew_rate_control;
  assign pif.dout    = r.data;
  assign pif.alt_out = alt_out_i;
  assign pif.alt_oe  = alt_oe_i;

  gpp_pad #(.W(W)) u_pad (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .cfg       (pif.pad),
    .out_o     (pad_out_o),
    .oe_o      (pad_oe_o),
    .pu_o      (pad_pu_o),
    .pd_o      (pad_pd_o),
    .dr4_o     (pad_dr4_o),
    .dr8_o     (pad_dr8_o),
    .slew_o    (pad_slew_o),
    .ana_o     (pad_ana_o)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o  = r.rdata;
  assign irq_o    = r.irq;
  assign alt_in_o = r.alt_in;
endmodule // gpp_port

//--- logic/gpp_sync.sv
// ----------------------------------------
// Two stage input synchroniser
// ----------------------------------------
module gpp_sync #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;  // First stage, read only by second
    logic [W-1:0] q;     // Second stage
  } gpp_sync_s;

  gpp_sync_s r, next_r;

  // Shift chain
  always_comb begin
    next_r      = r;
    next_r.meta = d_i;
    next_r.q    = r.meta;
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.q;
endmodule // gpp_sync
